// file: src/edm_pkg.sv
// Purpose: constants for the e3 receive defect monitor
// Assumes: 8-bit registers on a 32-bit classic wishbone, one word each
// Notes: register offsets are word indices, so byte address = 4 * index
package edm_pkg;
   localparam logic [15:0] IDX_CFG_ONE = 16'h1110;
   localparam logic [15:0] IDX_CFG_TWO = 16'h1111;
   localparam logic [15:0] IDX_INT_ONE = 16'h1114;
   localparam logic [15:0] IDX_INT_TWO = 16'h1115;
   localparam logic [15:0] IDX_INT_MASK_ONE = 16'h1118;
   localparam logic [15:0] IDX_INT_MASK_TWO = 16'h1119;
   localparam logic [15:0] IDX_CTRL = 16'h111a;
   localparam int CFG_FERF_SEL_BIT = 4;
   localparam int CFG_TMARK_BIT = 3;
   localparam int ST_AIS_BIT = 3;
   localparam int ST_FERF_BIT = 0;
   localparam int INT1_AIS_BIT = 0;
   localparam int INT2_FERF_BIT = 3;
   localparam int CTRL_AUTO_FERF_BIT = 0;
   localparam logic [7:0] CFG_ONE_RESET = 8'h02;
   localparam logic [7:0] CFG_ONE_WMASK = 8'h1f;
   localparam logic [7:0] MASK_RESET = 8'hff;
   localparam logic [3:0] AIS_ZERO_MAX = 4'h7;
   localparam logic [2:0] FERF_CNT_SHORT = 3'h3;
   localparam logic [2:0] FERF_CNT_LONG = 3'h5;
   localparam logic [15:0] ZERO_SAT = 16'hffff;
endpackage

// file: src/edm_filter.sv
// Purpose: consecutive-frame persistence filter for one defect
// Assumes: one frame_i pulse per frame with the frame's verdict in bad_i
// Notes: declares after need_i bad frames in a row, clears after need_i good ones
`timescale 1ns/1ps
`default_nettype none
module edm_filter (
   input wire logic clk_i, // system clock
   input wire logic rst_i, // sync reset, active high
   input wire logic frame_i, // frame end pulse
   input wire logic bad_i, // this frame shows the defect
   input wire logic [2:0] need_i, // consecutive frames required
   output logic defect_o // filtered defect state
);
   logic defect_reg, defect_next;
   logic [2:0] run_reg, run_next;

   always_comb begin
      defect_next = defect_reg;
      run_next = run_reg;
      if (frame_i) begin
         // run counts frames that disagree with the current state
         if (bad_i != defect_reg) begin
            if (run_reg + 3'h1 >= need_i) begin
               defect_next = bad_i;
               run_next = 3'h0;
            end else begin
               run_next = run_reg + 3'h1;
            end
         end else begin
            run_next = 3'h0;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         defect_reg <= 1'b0;
         run_reg <= 3'h0;
      end else begin
         defect_reg <= defect_next;
         run_reg <= run_next;
      end
   end

   assign defect_o = defect_reg;
endmodule
`default_nettype wire

// file: src/edm_monitor.sv
// Purpose: e3 receive ais and far-end failure defect monitor with wishbone registers
// Assumes: frame stream arrives as bit strobes with a frame-end marker, all pins synchronised
// Notes: interrupt flags clear on read; a new event in the read cycle survives
// How it works
// - a declared alarm indication clears after two frames in a row each hold eight or more zeros.
// - clearing the alarm indication drives its status bit 3 of the second config/status register to 0.
// - each change of the alarm indication state sets interrupt flag bit 0 and pulls the interrupt low.
// - far-end failure is declared after 3 (select 0) or 5 (select 1) frames in a row with the bit at 1.
// - the frame-count select is host-writable bit 4 of the first config/status register.
// - declaring far-end failure sets bit 0 of the second config/status register.
// - that status bit follows the live defect state and does not latch.
// - each change of far-end failure sets bit 3 of the second interrupt register and pulls the line low.
// - when enabled, the transmit far-end failure bit is asserted while los, lof/oof or ais is declared.
// - alarm indication is declared when two consecutive frames hold seven or fewer zeros.
// - far-end failure clears after 3 or 5 frames in a row with the bit at 0, per the select.
`timescale 1ns/1ps
`default_nettype none
module edm_monitor (
   input wire logic clk_i, // 100 mhz clock
   input wire logic rst_i, // sync reset, active high
   input wire logic [31:0] wb_adr_i, // byte address
   input wire logic [31:0] wb_dat_i, // write data
   input wire logic [3:0] wb_sel_i, // byte selects
   input wire logic wb_we_i, // write enable
   input wire logic wb_cyc_i, // cycle
   input wire logic wb_stb_i, // strobe
   output logic [31:0] wb_dat_o, // read data
   output logic wb_ack_o, // acknowledge
   input wire logic rx_bit_en_i, // pin: a received bit is valid
   input wire logic rx_bit_i, // pin: received bit value
   input wire logic rx_frame_end_i, // pin: last bit of the frame
   input wire logic rx_ferf_bit_i, // pin: far-end failure bit of this frame
   input wire logic los_i, // pin: loss of signal declared
   input wire logic lof_i, // pin: loss or out of frame declared
   output logic tx_ferf_o, // far-end failure bit to send
   output logic ais_o, // alarm indication defect
   output logic ferf_o, // far-end failure defect
   output logic irq_n_o // interrupt, active low
);
   // two-stage synchronisers for every pin input
   logic [5:0] pin_s1_reg, pin_s2_reg;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_s1_reg <= 6'h00;
         pin_s2_reg <= 6'h00;
      end else begin
         pin_s1_reg <= {lof_i, los_i, rx_ferf_bit_i, rx_frame_end_i, rx_bit_i, rx_bit_en_i};
         pin_s2_reg <= pin_s1_reg;
      end
   end
   logic bit_en, bit_val, frame_end, ferf_bit, los_s, lof_s;
   assign {lof_s, los_s, ferf_bit, frame_end, bit_val, bit_en} = pin_s2_reg;

   // zero counting per frame; previous frame verdict kept for the pair test
   logic [15:0] zeros_reg, zeros_next;
   logic prev_few_reg, prev_few_next;
   logic frame_pulse, few_now, pair_few, pair_many;
   logic [15:0] zeros_total;

   always_comb begin
      zeros_total = zeros_reg;
      if (bit_en && !bit_val && zeros_reg != edm_pkg::ZERO_SAT) begin
         zeros_total = zeros_reg + 16'h0001;
      end
      frame_pulse = bit_en && frame_end;
      few_now = zeros_total <= {12'h000, edm_pkg::AIS_ZERO_MAX};
      pair_few = prev_few_reg && few_now;
      pair_many = !prev_few_reg && !few_now;
      zeros_next = zeros_total;
      prev_few_next = prev_few_reg;
      if (frame_pulse) begin
         zeros_next = 16'h0000;
         prev_few_next = few_now;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         zeros_reg <= 16'h0000;
         prev_few_reg <= 1'b0;
      end else begin
         zeros_reg <= zeros_next;
         prev_few_reg <= prev_few_next;
      end
   end

   // ais state: declare on a quiet pair, clear on a busy pair, hold otherwise
   logic ais_reg, ais_next;
   always_comb begin
      ais_next = ais_reg;
      if (frame_pulse && pair_few) begin
         ais_next = 1'b1;
      end else if (frame_pulse && pair_many) begin
         ais_next = 1'b0;
      end
   end

   // registers
   logic [7:0] cfg_one_reg, cfg_one_next;
   logic [7:0] mask1_reg, mask1_next, mask2_reg, mask2_next;
   logic [7:0] int1_reg, int1_next, int2_reg, int2_next;
   logic ctrl_auto_reg, ctrl_auto_next;
   logic ack_reg, ack_next;
   logic [31:0] rdata_reg, rdata_next;
   logic ferf_live, ferf_prev_reg;
   logic irq_n_reg, irq_n_next, tx_ferf_reg, tx_ferf_next;

   logic [2:0] ferf_need;
   assign ferf_need = cfg_one_reg[edm_pkg::CFG_FERF_SEL_BIT] ? edm_pkg::FERF_CNT_LONG
                                                            : edm_pkg::FERF_CNT_SHORT;

   edm_filter u_ferf (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .frame_i(frame_pulse),
      .bad_i(ferf_bit),
      .need_i(ferf_need),
      .defect_o(ferf_live)
   );

   logic req;
   logic [15:0] idx;
   logic [7:0] status_two;
   assign req = wb_cyc_i && wb_stb_i && !ack_reg;
   assign idx = wb_adr_i[17:2];
   assign status_two = 8'((ais_reg ? 8'h01 << edm_pkg::ST_AIS_BIT : 8'h00)
                        | (ferf_live ? 8'h01 << edm_pkg::ST_FERF_BIT : 8'h00));

   always_comb begin
      ack_next = req;
      rdata_next = rdata_reg;
      cfg_one_next = cfg_one_reg;
      mask1_next = mask1_reg;
      mask2_next = mask2_reg;
      ctrl_auto_next = ctrl_auto_reg;
      int1_next = int1_reg;
      int2_next = int2_reg;
      if (req && wb_we_i && wb_sel_i[0]) begin
         unique case (idx)
            edm_pkg::IDX_CFG_ONE: cfg_one_next = (cfg_one_reg & ~edm_pkg::CFG_ONE_WMASK)
                                                 | (wb_dat_i[7:0] & edm_pkg::CFG_ONE_WMASK);
            edm_pkg::IDX_INT_MASK_ONE: mask1_next = wb_dat_i[7:0];
            edm_pkg::IDX_INT_MASK_TWO: mask2_next = wb_dat_i[7:0];
            edm_pkg::IDX_CTRL: ctrl_auto_next = wb_dat_i[edm_pkg::CTRL_AUTO_FERF_BIT];
            default: ;
         endcase
      end
      if (req && !wb_we_i) begin
         unique case (idx)
            edm_pkg::IDX_CFG_ONE: rdata_next = {24'h0, cfg_one_reg};
            edm_pkg::IDX_CFG_TWO: rdata_next = {24'h0, status_two};
            edm_pkg::IDX_INT_ONE: begin
               rdata_next = {24'h0, int1_reg};
               int1_next = 8'h00;
            end
            edm_pkg::IDX_INT_TWO: begin
               rdata_next = {24'h0, int2_reg};
               int2_next = 8'h00;
            end
            edm_pkg::IDX_INT_MASK_ONE: rdata_next = {24'h0, mask1_reg};
            edm_pkg::IDX_INT_MASK_TWO: rdata_next = {24'h0, mask2_reg};
            edm_pkg::IDX_CTRL: rdata_next = {31'h0, ctrl_auto_reg};
            default: rdata_next = 32'h0;
         endcase
      end
      // set wins over the clear-on-read in the same cycle
      if (ais_next != ais_reg) begin
         int1_next[edm_pkg::INT1_AIS_BIT] = 1'b1;
      end
      if (ferf_live != ferf_prev_reg) begin
         int2_next[edm_pkg::INT2_FERF_BIT] = 1'b1;
      end
      irq_n_next = !(|(int1_next & mask1_reg) || |(int2_next & mask2_reg));
      tx_ferf_next = ctrl_auto_reg && (los_s || lof_s || ais_reg);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg <= 1'b0;
         rdata_reg <= 32'h0;
         cfg_one_reg <= edm_pkg::CFG_ONE_RESET;
         mask1_reg <= edm_pkg::MASK_RESET;
         mask2_reg <= edm_pkg::MASK_RESET;
         ctrl_auto_reg <= 1'b0;
         int1_reg <= 8'h00;
         int2_reg <= 8'h00;
         ais_reg <= 1'b0;
         ferf_prev_reg <= 1'b0;
         irq_n_reg <= 1'b1;
         tx_ferf_reg <= 1'b0;
      end else begin
         ack_reg <= ack_next;
         rdata_reg <= rdata_next;
         cfg_one_reg <= cfg_one_next;
         mask1_reg <= mask1_next;
         mask2_reg <= mask2_next;
         ctrl_auto_reg <= ctrl_auto_next;
         int1_reg <= int1_next;
         int2_reg <= int2_next;
         ais_reg <= ais_next;
         ferf_prev_reg <= ferf_live;
         irq_n_reg <= irq_n_next;
         tx_ferf_reg <= tx_ferf_next;
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = rdata_reg;
   assign ais_o = ais_reg;
   assign ferf_o = ferf_live;
   assign irq_n_o = irq_n_reg;
   assign tx_ferf_o = tx_ferf_reg;

   // checks
   a_ais_clear_pair: assert property (@(posedge clk_i) disable iff (rst_i)
      frame_pulse && pair_many |=> !ais_reg) else $error("ais not cleared");
   a_ais_declare: assert property (@(posedge clk_i) disable iff (rst_i)
      frame_pulse && pair_few |=> ais_reg) else $error("ais not declared");
   a_ais_flag_set: assert property (@(posedge clk_i) disable iff (rst_i)
      $changed(ais_reg) |-> int1_reg[edm_pkg::INT1_AIS_BIT])
      else $error("ais flag missing");
   a_ferf_flag_set: assert property (@(posedge clk_i) disable iff (rst_i)
      $changed(ferf_live) |=> int2_reg[edm_pkg::INT2_FERF_BIT])
      else $error("ferf flag missing");
   a_ferf_status_live: assert property (@(posedge clk_i) disable iff (rst_i)
      ack_reg && $past(!wb_we_i && idx == edm_pkg::IDX_CFG_TWO)
      |-> wb_dat_o[edm_pkg::ST_FERF_BIT] == $past(ferf_live)
          && wb_dat_o[edm_pkg::ST_AIS_BIT] == $past(ais_reg))
      else $error("status two wrong");
   a_ferf_sel_write: assert property (@(posedge clk_i) disable iff (rst_i)
      req && wb_we_i && wb_sel_i[0] && idx == edm_pkg::IDX_CFG_ONE
      |=> cfg_one_reg[edm_pkg::CFG_FERF_SEL_BIT] == $past(wb_dat_i[edm_pkg::CFG_FERF_SEL_BIT]))
      else $error("select not written");
   // the filter may only move at a frame end, and only towards that frame's verdict
   a_ferf_needs_run: assert property (@(posedge clk_i) disable iff (rst_i)
      $changed(ferf_live) |-> $past(frame_pulse) && $past(ferf_bit) == ferf_live)
      else $error("ferf moved off a frame");
   a_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
      irq_n_o == !(|(int1_reg & $past(mask1_reg)) || |(int2_reg & $past(mask2_reg))))
      else $error("irq level wrong");
   a_tx_ferf_auto: assert property (@(posedge clk_i) disable iff (rst_i)
      ctrl_auto_reg && ais_reg |=> tx_ferf_o) else $error("tx ferf not sent");
   c_ais_rise: cover property (@(posedge clk_i) $rose(ais_reg));
   c_ais_fall: cover property (@(posedge clk_i) $fell(ais_reg));
   c_ferf_long: cover property (@(posedge clk_i) cfg_one_reg[4] && $rose(ferf_live));
   c_irq_low: cover property (@(posedge clk_i) $fell(irq_n_o));
endmodule
`default_nettype wire

// file: testbench/edm_far_end.sv
// Purpose: remote e3 terminal model driving the received frame stream
// Assumes: short test frames of nbits bits, the zero bits placed first
// Notes: between frames data and ferf lines show the inverse of their last value
`timescale 1ns/1ps
`default_nettype none
module edm_far_end (
   input wire logic clk_i, // system clock
   output logic bit_en_o, // a bit is valid
   output logic bit_o, // bit value
   output logic frame_end_o, // last bit of the frame
   output logic ferf_bit_o // far-end failure bit of the frame
);
   initial begin
      bit_en_o = 1'b0;
      bit_o = 1'b1;
      frame_end_o = 1'b0;
      ferf_bit_o = 1'b0;
   end
   // ferf is held over the whole frame, so its sampling point inside the frame is free
   task automatic send_frame(input int nbits, input int nzeros, input logic ferf);
      for (int i = 0; i < nbits; i++) begin
         @(posedge clk_i);
         bit_en_o <= 1'b1;
         bit_o <= (i < nzeros) ? 1'b0 : 1'b1;
         frame_end_o <= (i == nbits - 1);
         ferf_bit_o <= ferf;
      end
      @(posedge clk_i);
      bit_en_o <= 1'b0;
      frame_end_o <= 1'b0;
      bit_o <= ~bit_o;
      ferf_bit_o <= ~ferf;
   endtask
endmodule
`default_nettype wire

// file: testbench/edm_monitor_test.sv
// Purpose: self-checking bench for the e3 receive defect monitor
// Assumes: registers reached by classic wishbone reads and writes
// Notes: frames are 12 bits, so zero counts of 7 and 8 sit on the boundary
`timescale 1ns/1ps
`default_nettype none
module edm_monitor_test;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_we = 1'b0;
   logic wb_cyc = 1'b0;
   logic wb_stb = 1'b0;
   logic los = 1'b0;
   logic lof = 1'b0;
   logic [31:0] wb_adr = 32'h0;
   logic [31:0] wb_dat = 32'h0;
   logic [3:0] wb_sel = 4'h0;
   logic [31:0] rd;
   logic [31:0] wb_dat_o;
   logic wb_ack_o, bit_en, rx_bit, fend, fbit, tx_ferf, ais, ferf, irq_n;
   int n_mismatch = 0;
   int n_checks = 0;
   edm_monitor dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr), .wb_dat_i(wb_dat),
      .wb_sel_i(wb_sel), .wb_we_i(wb_we), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_bit_en_i(bit_en), .rx_bit_i(rx_bit),
      .rx_frame_end_i(fend), .rx_ferf_bit_i(fbit), .los_i(los), .lof_i(lof),
      .tx_ferf_o(tx_ferf), .ais_o(ais), .ferf_o(ferf), .irq_n_o(irq_n));
   edm_far_end far (.clk_i(clk_i), .bit_en_o(bit_en), .bit_o(rx_bit), .frame_end_o(fend),
      .ferf_bit_o(fbit));
   initial begin
      forever #5 clk_i = ~clk_i;
   end
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      chk({31'h0, got}, {31'h0, exp});
   endtask
   // single classic cycle; the request is held until ack is seen at a rising edge
   task automatic wb(input logic [15:0] idx, input logic we, input logic [7:0] d);
      @(posedge clk_i);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= {14'h0, idx, 2'b00};
      wb_dat <= {24'h0, d};
      wb_sel <= 4'hf;
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_we <= 1'b0;
   endtask
   task automatic rd_chk(input logic [15:0] idx, input logic [7:0] exp);
      wb(idx, 1'b0, 8'h00);
      chk(rd, {24'h0, exp});
   endtask
   // pins pass two sync flops and the defect logic one more, so 5 edges settle all
   task automatic frames(input int n, input int z, input logic f);
      repeat (n) far.send_frame(12, z, f);
      repeat (5) @(posedge clk_i);
   endtask
   initial begin
      repeat (20000) @(posedge clk_i);
      n_mismatch++;
      summarize();
   end
   initial begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      rd_chk(edm_pkg::IDX_CFG_ONE, 8'h02);
      rd_chk(edm_pkg::IDX_CFG_TWO, 8'h00);
      chk1(irq_n, 1'b1);
      wb(edm_pkg::IDX_CFG_ONE, 1'b1, 8'hff);
      rd_chk(edm_pkg::IDX_CFG_ONE, 8'h1f);
      rd_chk(16'h1200, 8'h00);
      wb(edm_pkg::IDX_CFG_ONE, 1'b1, 8'h02);
      frames(1, 7, 1'b0);
      chk1(ais, 1'b0);
      frames(1, 7, 1'b0);
      chk1(ais, 1'b1);
      chk1(irq_n, 1'b0);
      chk1(tx_ferf, 1'b0);
      rd_chk(edm_pkg::IDX_CFG_TWO, 8'h08);
      rd_chk(edm_pkg::IDX_INT_ONE, 8'h01);
      rd_chk(edm_pkg::IDX_INT_ONE, 8'h00);
      repeat (2) @(posedge clk_i);
      chk1(irq_n, 1'b1);
      frames(1, 8, 1'b0);
      chk1(ais, 1'b1);
      frames(1, 8, 1'b0);
      chk1(ais, 1'b0);
      rd_chk(edm_pkg::IDX_CFG_TWO, 8'h00);
      rd_chk(edm_pkg::IDX_INT_ONE, 8'h01);
      frames(2, 8, 1'b1);
      chk1(ferf, 1'b0);
      frames(1, 8, 1'b1);
      chk1(ferf, 1'b1);
      rd_chk(edm_pkg::IDX_CFG_TWO, 8'h01);
      rd_chk(edm_pkg::IDX_INT_TWO, 8'h08);
      frames(2, 8, 1'b1);
      rd_chk(edm_pkg::IDX_CFG_TWO, 8'h01);
      frames(2, 8, 1'b0);
      chk1(ferf, 1'b1);
      frames(1, 8, 1'b0);
      chk1(ferf, 1'b0);
      rd_chk(edm_pkg::IDX_INT_TWO, 8'h08);
      wb(edm_pkg::IDX_CFG_ONE, 1'b1, 8'h12);
      wb(edm_pkg::IDX_INT_MASK_TWO, 1'b1, 8'h00);
      frames(4, 8, 1'b1);
      chk1(ferf, 1'b0);
      frames(1, 8, 1'b1);
      chk1(ferf, 1'b1);
      chk1(irq_n, 1'b1);
      frames(4, 8, 1'b0);
      chk1(ferf, 1'b1);
      frames(1, 8, 1'b0);
      chk1(ferf, 1'b0);
      wb(edm_pkg::IDX_INT_MASK_TWO, 1'b1, 8'hff);
      repeat (2) @(posedge clk_i);
      chk1(irq_n, 1'b0);
      rd_chk(edm_pkg::IDX_INT_TWO, 8'h08);
      wb(edm_pkg::IDX_CTRL, 1'b1, 8'h01);
      los <= 1'b1;
      repeat (6) @(posedge clk_i);
      chk1(tx_ferf, 1'b1);
      los <= 1'b0;
      lof <= 1'b1;
      repeat (6) @(posedge clk_i);
      chk1(tx_ferf, 1'b1);
      lof <= 1'b0;
      repeat (6) @(posedge clk_i);
      chk1(tx_ferf, 1'b0);
      wb(edm_pkg::IDX_INT_MASK_ONE, 1'b1, 8'h00);
      frames(2, 7, 1'b0);
      chk1(tx_ferf, 1'b1);
      chk1(irq_n, 1'b1);
      rd_chk(edm_pkg::IDX_INT_MASK_ONE, 8'h00);
      rd_chk(edm_pkg::IDX_CTRL, 8'h01);
      rd_chk(edm_pkg::IDX_INT_ONE, 8'h01);
      frames(2, 8, 1'b0);
      chk1(tx_ferf, 1'b0);
      wb(edm_pkg::IDX_INT_MASK_ONE, 1'b1, 8'hff);
      repeat (2) @(posedge clk_i);
      chk1(irq_n, 1'b0);
      summarize();
   end
endmodule
`default_nettype wire
